/* hw/spdaux_rx_aux.sv */
// Purpose: capture receiver auxiliary bits into 192-frame banks, serve over APB, emit TDM8
// Assumes: clk_link_in is the recovered bit clock, frame_strobe_in one link cycle per frame
// Notes: clock generator 3 clocks arrive as pins and must be frequency locked to the link
`timescale 1ns/1ps
module spdaux_rx_aux #(
    parameter int unsigned ADDR_W = 18,
    parameter int unsigned NUM_PORTS = 4
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic clk_link_in,
    input wire logic frame_strobe_in,
    input wire logic [23:0] audio_left_in,
    input wire logic [23:0] audio_right_in,
    input wire logic [3:0] pvuc_left_in,
    input wire logic [3:0] pvuc_right_in,
    input wire logic compr_type_in,
    input wire logic audio_type_in,
    input wire logic block_start_in,
    input wire logic clkgen3_bit_clock_in,
    input wire logic clkgen3_frame_clock_in,
    output logic [3:0] serial_output_data_pin_out,
    output logic [3:0] serial_output_bit_clock_out,
    output logic [3:0] serial_output_frame_clock_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // link domain reset and frame latch
    logic rst_link_meta_reg;
    logic rst_link_reg;
    logic [4:0] frame_aux_reg;
    logic [23:0] aud_l_reg;
    logic [23:0] aud_r_reg;
    logic [3:0] pvuc_l_reg;
    logic [3:0] pvuc_r_reg;
    logic [1:0] type_reg;
    logic frame_tog_reg;

    // reset release synchronised to the link clock
    always_ff @(posedge clk_link_in or posedge reset_in) begin
        if (reset_in) begin
            rst_link_meta_reg <= 1'b1;
            rst_link_reg <= 1'b1;
        end else begin
            rst_link_meta_reg <= 1'b0;
            rst_link_reg <= rst_link_meta_reg;
        end
    end

    // hold one frame; toggle tells the system side a new frame is stable
    always_ff @(posedge clk_link_in or posedge rst_link_reg) begin
        if (rst_link_reg) begin
            frame_aux_reg <= 5'h00;
            aud_l_reg <= 24'h000000;
            aud_r_reg <= 24'h000000;
            pvuc_l_reg <= 4'h0;
            pvuc_r_reg <= 4'h0;
            type_reg <= 2'h0;
            frame_tog_reg <= 1'b0;
        end else if (frame_strobe_in) begin
            // bit 4 block start, then right ud, left ud, right cs, left cs
            frame_aux_reg <= {block_start_in, pvuc_right_in[1], pvuc_left_in[1],
                              pvuc_right_in[0], pvuc_left_in[0]};
            aud_l_reg <= audio_left_in;
            aud_r_reg <= audio_right_in;
            pvuc_l_reg <= pvuc_left_in;
            pvuc_r_reg <= pvuc_right_in;
            type_reg <= {compr_type_in, audio_type_in};
            frame_tog_reg <= ~frame_tog_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // TDM8 serializer on the link clock
    logic [7:0] bit_cnt_reg;
    logic sdata_reg;
    logic fclk_reg;
    logic [spdaux_pkg::CTRL_W-1:0] ctrl_reg;
    logic [spdaux_pkg::CTRL_W-1:0] ctrl_meta_reg;
    logic [spdaux_pkg::CTRL_W-1:0] ctrl_link_reg;
    logic [3:0] port_en;
    logic clk_sel_link;

    // one bit of the frame: slot from counter top bits, msb of the slot first
    function automatic logic slot_bit(input logic [7:0] cnt);
        logic [31:0] w;
        w = 32'h00000000;
        case (cnt[7:5])
            3'h0: w = {aud_l_reg, 8'h00}; // R11
            3'h1: w = {20'h00000, pvuc_l_reg, 8'h00}; // R11
            3'h2: w = {22'h000000, type_reg, 8'h00}; // R11
            3'h4: w = {aud_r_reg, 8'h00}; // R11
            3'h5: w = {20'h00000, pvuc_r_reg, 8'h00}; // R11
            3'h7: w = {23'h000000, frame_aux_reg[4], 8'h00}; // R11
            default: w = 32'h00000000; // R11
        endcase
        return w[~cnt[4:0]];
    endfunction

    // control word into the link domain; changes only while software reconfigures
    always_ff @(posedge clk_link_in or posedge rst_link_reg) begin
        if (rst_link_reg) begin
            ctrl_meta_reg <= spdaux_pkg::CTRL_RESET;
            ctrl_link_reg <= spdaux_pkg::CTRL_RESET;
        end else begin
            ctrl_meta_reg <= ctrl_reg;
            ctrl_link_reg <= ctrl_meta_reg;
        end
    end

    // bit counter restarts on each frame strobe, data msb first
    always_ff @(posedge clk_link_in or posedge rst_link_reg) begin
        if (rst_link_reg) begin
            bit_cnt_reg <= 8'h00;
            sdata_reg <= 1'b0;
            fclk_reg <= 1'b0;
        end else begin
            bit_cnt_reg <= frame_strobe_in ? 8'h00 : bit_cnt_reg + 8'h01;
            sdata_reg <= slot_bit(bit_cnt_reg); // R11
            fclk_reg <= bit_cnt_reg < spdaux_pkg::FRAME_BITS_HALF;
        end
    end

    // only a one-hot select routes; anything else leaves all ports quiet
    assign port_en = $onehot(ctrl_link_reg[3:0]) ? ctrl_link_reg[3:0] : spdaux_pkg::PORT_OFF; // R1
    assign clk_sel_link = ctrl_link_reg[spdaux_pkg::CTRL_CLK_BIT];

    // port pins; clock source picked by the clock-select bit
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            serial_output_data_pin_out[p] = port_en[p] & sdata_reg; // R1
            serial_output_bit_clock_out[p] = port_en[p] &
                (clk_sel_link ? clkgen3_bit_clock_in : clk_link_in); // R3 R4
            serial_output_frame_clock_out[p] = port_en[p] &
                (clk_sel_link ? clkgen3_frame_clock_in : fclk_reg); // R3 R4
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frame capture in the system domain
    logic tog_meta_reg;
    logic tog_sync_reg;
    logic tog_seen_reg;
    logic frame_evt;
    logic [7:0] idx_reg;
    logic [7:0] wr_idx;
    logic wr_ok;
    logic ready_reg;
    logic [15:0] bank_reg [spdaux_pkg::NUM_BANKS][spdaux_pkg::BANK_WORDS];

    // toggle synchroniser for the frame event
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            tog_meta_reg <= 1'b0;
            tog_sync_reg <= 1'b0;
            tog_seen_reg <= 1'b0;
        end else begin
            tog_meta_reg <= frame_tog_reg;
            tog_sync_reg <= tog_meta_reg;
            tog_seen_reg <= tog_sync_reg;
        end
    end

    assign frame_evt = tog_sync_reg ^ tog_seen_reg;
    // frames before the first block start are dropped
    assign wr_idx = frame_aux_reg[4] ? 8'h00 :
                    (idx_reg == spdaux_pkg::FRAME_NONE) ? idx_reg : idx_reg + 8'h01;
    assign wr_ok = wr_idx < spdaux_pkg::FRAME_NONE;

    // frame position in the block
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            idx_reg <= spdaux_pkg::FRAME_NONE;
        end else if (frame_evt) begin
            idx_reg <= wr_idx; // R6
        end
    end

    // store one bit per bank, block bit n in word n/16, bit n%16
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            for (int b = 0; b < spdaux_pkg::NUM_BANKS; b++) begin
                for (int w = 0; w < spdaux_pkg::BANK_WORDS; w++) begin
                    bank_reg[b][w] <= 16'h0000; // R8 R9 R10 R12
                end
            end
        end else if (frame_evt && wr_ok) begin
            for (int b = 0; b < spdaux_pkg::NUM_BANKS; b++) begin
                bank_reg[b][wr_idx[7:4]][wr_idx[3:0]] <= frame_aux_reg[b]; // R13
            end
        end
    end

    // complete after the last frame; a new block start withdraws it
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ready_reg <= 1'b0; // R7
        end else if (frame_evt && wr_ok && wr_idx == spdaux_pkg::FRAME_LAST) begin
            ready_reg <= 1'b1; // R6
        end else if (frame_evt && frame_aux_reg[4]) begin
            ready_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    logic [15:0] acc_idx;
    logic dec_hit;
    logic [15:0] dec_data;
    logic [31:0] prdata_reg;
    logic err_reg;

    // is index inside a 12-word bank
    function automatic logic in_bank(input logic [15:0] i, input logic [15:0] base);
        return (i >= base) && (i < base + 16'(spdaux_pkg::BANK_WORDS));
    endfunction

    assign acc_idx = 16'(paddr_in[ADDR_W-1:spdaux_pkg::BYTE_SHIFT]);

    // address decode
    always_comb begin
        dec_hit = 1'b1;
        dec_data = 16'h0000;
        if (paddr_in[1:0] != 2'h0) begin
            dec_hit = 1'b0;
        end else if (acc_idx == spdaux_pkg::IDX_CTRL) begin
            dec_data = 16'(ctrl_reg);
        end else if (acc_idx == spdaux_pkg::IDX_READY) begin
            dec_data = {15'h0000, ready_reg}; // R7
        end else if (in_bank(acc_idx, spdaux_pkg::IDX_CS_L)) begin
            dec_data = bank_reg[spdaux_pkg::BK_CS_L][4'(acc_idx - spdaux_pkg::IDX_CS_L)]; // R8
        end else if (in_bank(acc_idx, spdaux_pkg::IDX_CS_R)) begin
            dec_data = bank_reg[spdaux_pkg::BK_CS_R][4'(acc_idx - spdaux_pkg::IDX_CS_R)]; // R9
        end else if (in_bank(acc_idx, spdaux_pkg::IDX_UD_L)) begin
            dec_data = bank_reg[spdaux_pkg::BK_UD_L][4'(acc_idx - spdaux_pkg::IDX_UD_L)]; // R10
        end else if (in_bank(acc_idx, spdaux_pkg::IDX_UD_R)) begin
            dec_data = bank_reg[spdaux_pkg::BK_UD_R][4'(acc_idx - spdaux_pkg::IDX_UD_R)]; // R12
        end else begin
            dec_hit = 1'b0;
        end
    end

    // read data and error latched in the setup cycle
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            prdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
        end else if (psel_in && !penable_in) begin
            prdata_reg <= pwrite_in ? 32'h00000000 : {16'h0000, dec_data};
            err_reg <= !dec_hit;
        end
    end

    // only the control register takes writes; banks and flag are read-only
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_reg <= spdaux_pkg::CTRL_RESET;
        end else if (psel_in && penable_in && pwrite_in && dec_hit &&
                     acc_idx == spdaux_pkg::IDX_CTRL) begin
            ctrl_reg <= pwdata_in[spdaux_pkg::CTRL_W-1:0];
        end
    end

    assign pready_out = 1'b1;
    assign prdata_out = prdata_reg;
    assign pslverr_out = psel_in & penable_in & err_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_ready_set;
        @(posedge clk_sys_in) disable iff (reset_in)
        frame_evt && wr_ok && wr_idx == spdaux_pkg::FRAME_LAST |=> ready_reg;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set"); // R6

    property p_ready_rise;
        @(posedge clk_sys_in) disable iff (reset_in)
        $rose(ready_reg) |-> $past(idx_reg) != spdaux_pkg::FRAME_LAST && idx_reg == spdaux_pkg::FRAME_LAST;
    endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("ready rose early"); // R6

    property p_ready_read;
        @(posedge clk_sys_in) disable iff (reset_in)
        psel_in && !penable_in && !pwrite_in && acc_idx == spdaux_pkg::IDX_READY
        |=> prdata_out == {31'h00000000, $past(ready_reg)};
    endproperty
    a_ready_read: assert property (p_ready_read) else $error("ready read wrong"); // R7

    property p_cs_left;
        @(posedge clk_sys_in) disable iff (reset_in)
        frame_evt && wr_ok |=> bank_reg[0][$past(wr_idx[7:4])][$past(wr_idx[3:0])]
            == $past(frame_aux_reg[0]);
    endproperty
    a_cs_left: assert property (p_cs_left) else $error("left status bit lost"); // R8

    property p_cs_right;
        @(posedge clk_sys_in) disable iff (reset_in)
        frame_evt && wr_ok |=> bank_reg[1][$past(wr_idx[7:4])][$past(wr_idx[3:0])]
            == $past(frame_aux_reg[1]);
    endproperty
    a_cs_right: assert property (p_cs_right) else $error("right status bit lost"); // R9

    property p_ud_left;
        @(posedge clk_sys_in) disable iff (reset_in)
        frame_evt && wr_ok |=> bank_reg[2][$past(wr_idx[7:4])][$past(wr_idx[3:0])]
            == $past(frame_aux_reg[2]);
    endproperty
    a_ud_left: assert property (p_ud_left) else $error("left user bit lost"); // R10

    property p_ud_right;
        @(posedge clk_sys_in) disable iff (reset_in)
        frame_evt && frame_aux_reg[4] |=> bank_reg[3][0][0] == $past(frame_aux_reg[3]);
    endproperty
    a_ud_right: assert property (p_ud_right) else $error("right user bit 0 lost"); // R12 R13

    property p_route;
        @(posedge clk_link_in) disable iff (rst_link_reg)
        ((serial_output_data_pin_out & ~ctrl_link_reg[3:0]) == 4'h0)
            && (ctrl_link_reg[3:0] != 4'h0 || serial_output_frame_clock_out == 4'h0);
    endproperty
    a_route: assert property (p_route) else $error("data on unselected port"); // R1

    property p_fclk_src;
        @(posedge clk_link_in) disable iff (rst_link_reg)
        port_en != 4'h0 && !clk_sel_link |-> (serial_output_frame_clock_out != 4'h0) == fclk_reg;
    endproperty
    a_fclk_src: assert property (p_fclk_src) else $error("frame clock source wrong"); // R3

    property p_zero_slot;
        @(posedge clk_link_in) disable iff (rst_link_reg)
        bit_cnt_reg[7:5] == 3'h3 && !frame_strobe_in |=> !sdata_reg;
    endproperty
    a_zero_slot: assert property (p_zero_slot) else $error("slot 3 not zero"); // R11
endmodule // spdaux_rx_aux

/* hw/spdaux_pkg.sv */
// Purpose: constants for the receiver auxiliary-bit capture and TDM8 output block
// Assumes: register indices as printed; byte address is index times four
// Notes: the operation list below is the behaviour the block keeps
// Operation
// (R1) port-select one-hot 0001..1000 routes TDM to output 0..3; 0000 disables
// (R2) controller must configure the selected serial output port as clock master
// (R3) clock-select 0 drives bit and frame clocks from recovered input clocks
// (R4) clock-select 1 drives bit and frame clocks from clock generator 3
// (R5) controller sets generator 3 reference 0b1110 and source bit before selecting it
// (R6) bits gathered per frame; after 192 frames the complete flag goes 0 to 1
// (R7) complete flag is read-only, resets 0; 1 means bits available
// (R8) left channel-status bits in 12 read-only words from 0xf610, reset zero
// (R9) right channel-status bits in 12 read-only words from 0xf620, reset zero
// (R10) left user-data bits in 12 read-only words from 0xf630, reset zero
// (R11) TDM8 slots: audio, P/V/U/C, type bits, block start; all else zero
// (R12) right user-data bits in 12 read-only words from 0xf640
// (R13) lowest word holds block bits 0..15, bit 0 in bit 0, ascending
package spdaux_pkg;
    // block geometry
    localparam int unsigned BLOCK_FRAMES = 192;
    localparam int unsigned BANK_WORDS = 12;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned NUM_BANKS = 4;
    localparam logic [7:0] FRAME_LAST = 8'hbf;
    localparam logic [7:0] FRAME_NONE = 8'hc0;
    // register indices, byte address = index << 2
    localparam logic [15:0] IDX_CTRL = 16'hf608;
    localparam logic [15:0] IDX_READY = 16'hf60f;
    localparam logic [15:0] IDX_CS_L = 16'hf610;
    localparam logic [15:0] IDX_CS_R = 16'hf620;
    localparam logic [15:0] IDX_UD_L = 16'hf630;
    localparam logic [15:0] IDX_UD_R = 16'hf640;
    localparam int unsigned BYTE_SHIFT = 2;
    // control register layout
    localparam int unsigned CTRL_W = 5;
    localparam int unsigned CTRL_CLK_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [3:0] PORT_OFF = 4'h0;
    // bank order inside the captured frame bits
    localparam int unsigned BK_CS_L = 0;
    localparam int unsigned BK_CS_R = 1;
    localparam int unsigned BK_UD_L = 2;
    localparam int unsigned BK_UD_R = 3;
    // TDM8 frame layout, msb first
    localparam int unsigned SLOT_W = 32;
    localparam int unsigned AUDIO_W = 24;
    localparam int unsigned TRAIL_ZEROS = 8;
    localparam logic [7:0] FRAME_BITS_HALF = 8'h80;
endpackage

/* sim/spdaux_src_model.sv */
// Purpose: behavioural receiver front end that hands decoded frames to the block
// Assumes: every field is a fixed function of the frame index, so the bench can predict it
// Notes: frames stop and the index rewinds to 0 while run_in is low
`timescale 1ns/1ps
module spdaux_src_model (
    input wire logic clk_link_in,
    input wire logic run_in,
    input wire logic [8:0] gap_in,
    output logic frame_strobe_out,
    output logic [23:0] audio_left_out,
    output logic [23:0] audio_right_out,
    output logic [3:0] pvuc_left_out,
    output logic [3:0] pvuc_right_out,
    output logic compr_type_out,
    output logic audio_type_out,
    output logic block_start_out,
    output logic [7:0] frame_idx_out
);
    logic [8:0] gap_reg = 9'h000;
    logic [7:0] n_reg = 8'h00;
    ////////////////////////////////////////////////////////////////////////////////
    // one strobe every gap_in link cycles; fields hold until the next strobe
    initial begin
        {frame_strobe_out, audio_left_out, audio_right_out} = '0;
        {pvuc_left_out, pvuc_right_out, compr_type_out, audio_type_out} = '0;
        {block_start_out, frame_idx_out} = '0;
    end
    always @(posedge clk_link_in) begin
        if (!run_in) begin
            gap_reg <= 9'h000;
            n_reg <= 8'h00;
            frame_strobe_out <= 1'b0;
        end else begin
            frame_strobe_out <= (gap_reg == 9'h000);
            gap_reg <= (gap_reg == gap_in - 9'h001) ? 9'h000 : gap_reg + 9'h001;
            if (gap_reg == 9'h000) begin
                frame_idx_out <= n_reg;
                audio_left_out <= {n_reg, 16'hc35a};
                audio_right_out <= {16'h9e21, n_reg};
                pvuc_left_out <= {2'b10, n_reg[1], n_reg[0] ^ n_reg[3]};
                pvuc_right_out <= {2'b01, n_reg[0], n_reg[2]};
                compr_type_out <= n_reg[0];
                audio_type_out <= n_reg[1];
                block_start_out <= (n_reg == 8'h00); // 192-frame block marker
                n_reg <= (n_reg == 8'hbf) ? 8'h00 : n_reg + 8'h01;
            end
        end
    end
endmodule // spdaux_src_model

/* sim/spdaux_rx_aux_tb_top.sv */
// Purpose: self-checking bench for the auxiliary-bit capture and TDM8 output block
// Assumes: control changes only while no frames run
// Notes: generator 3 clocks are modelled as inverted link clock and a slow frame clock
`timescale 1ns/1ps
module spdaux_rx_aux_tb_top;
    logic clk_sys_in = 1'b0;
    logic clk_link_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [17:0] paddr_in = 18'h00000;
    logic [31:0] pwdata_in = 32'h00000000;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, frame_strobe_in, compr_type_in, audio_type_in, block_start_in;
    logic [23:0] audio_left_in, audio_right_in;
    logic [3:0] pvuc_left_in, pvuc_right_in, sdo, bclk, fclk;
    logic [7:0] frame_idx;
    logic [8:0] gap = 9'h010;
    logic run = 1'b0;
    logic cg3_fclk = 1'b0;
    logic [2:0] cg3_cnt = 3'h0;
    int n_mismatch = 0;
    int compares = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // clocks, generator 3 stand-in, design and partner
    always #2 clk_sys_in = ~clk_sys_in;
    always #3 clk_link_in = ~clk_link_in;
    always @(posedge clk_link_in) begin
        cg3_cnt <= cg3_cnt + 3'h1;
        if (cg3_cnt == 3'h7) cg3_fclk <= ~cg3_fclk;
    end
    spdaux_rx_aux spdaux_rx_aux_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .clk_link_in(clk_link_in), .frame_strobe_in(frame_strobe_in),
        .audio_left_in(audio_left_in), .audio_right_in(audio_right_in),
        .pvuc_left_in(pvuc_left_in), .pvuc_right_in(pvuc_right_in),
        .compr_type_in(compr_type_in), .audio_type_in(audio_type_in),
        .block_start_in(block_start_in), .clkgen3_bit_clock_in(~clk_link_in),
        .clkgen3_frame_clock_in(cg3_fclk), .serial_output_data_pin_out(sdo),
        .serial_output_bit_clock_out(bclk), .serial_output_frame_clock_out(fclk));
    spdaux_src_model spdaux_src_model_inst (.clk_link_in(clk_link_in), .run_in(run),
        .gap_in(gap), .frame_strobe_out(frame_strobe_in), .audio_left_out(audio_left_in),
        .audio_right_out(audio_right_in), .pvuc_left_out(pvuc_left_in),
        .pvuc_right_out(pvuc_right_in), .compr_type_out(compr_type_in),
        .audio_type_out(audio_type_in), .block_start_out(block_start_in),
        .frame_idx_out(frame_idx));
    ////////////////////////////////////////////////////////////////////////////////
    // reporting and bus tasks
    task automatic wrap_up();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int i;
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= {idx, 2'b00};
        pwdata_in <= wd;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys_in);
            if (pready_out === 1'b1) break;
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_sys_in);
        if (i == 50) begin
            n_mismatch++;
            wrap_up();
        end
    endtask
    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 32'h00000000, d, e);
        chk(d, exp);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, v, d, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        logic [31:0] d;
        logic e;
        rd_chk(spdaux_pkg::IDX_READY, 32'h0);
        rd_chk(spdaux_pkg::IDX_CS_L, 32'h0);
        rd_chk(spdaux_pkg::IDX_CS_R + 16'hb, 32'h0);
        rd_chk(spdaux_pkg::IDX_UD_L + 16'h5, 32'h0);
        rd_chk(spdaux_pkg::IDX_UD_R, 32'h0);
        rd_chk(spdaux_pkg::IDX_CTRL, 32'h0);
        wr(spdaux_pkg::IDX_READY, 32'h1);
        rd_chk(spdaux_pkg::IDX_READY, 32'h0);
        apb(1'b0, 16'hf600, 32'h0, d, e);
        chk({31'h0, e}, 32'h1);
    endtask
    task automatic t_block();
        logic [31:0] d;
        logic e;
        logic [15:0] x;
        logic [15:0] base [4] = '{16'hf610, 16'hf620, 16'hf630, 16'hf640};
        logic [7:0] n;
        int i, b, w, k;
        gap <= 9'h010;
        run <= 1'b1;
        for (i = 0; i < 4000; i++) begin
            apb(1'b0, spdaux_pkg::IDX_READY, 32'h0, d, e);
            if (d[0] === 1'b1) break;
        end
        run <= 1'b0;
        chk({24'h0, frame_idx}, 32'hbf);
        if (i == 4000) begin
            n_mismatch++;
            wrap_up();
        end
        for (b = 0; b < 4; b++) begin
            for (w = 0; w < 12; w++) begin
                for (k = 0; k < 16; k++) begin
                    n = 8'(16 * w + k);
                    x[k] = (b == 0) ? n[0] ^ n[3] : (b == 1) ? n[2] : (b == 2) ? n[1] : n[0];
                end
                rd_chk(base[b] + 16'(w), {16'h0, x});
            end
        end
    endtask
    task automatic t_tdm(input int p);
        logic [255:0] got, exp;
        logic prev, quiet;
        int i, rises;
        wr(spdaux_pkg::IDX_CTRL, 32'h1 << p);
        repeat (10) @(posedge clk_sys_in);
        gap <= 9'h100;
        run <= 1'b1;
        {prev, rises, quiet} = {1'b1, 32'd0, 1'b1};
        for (i = 0; i < 2000 && rises < 2; i++) begin
            @(negedge clk_link_in);
            if (prev === 1'b0 && fclk[p] === 1'b1) rises++;
            prev = fclk[p];
        end
        if (rises < 2) begin
            n_mismatch++;
            wrap_up();
        end
        exp = {audio_left_in, 8'h0, 20'h0, pvuc_left_in, 8'h0, 22'h0, compr_type_in,
               audio_type_in, 8'h0, 32'h0, audio_right_in, 8'h0, 20'h0, pvuc_right_in,
               8'h0, 32'h0, 23'h0, block_start_in, 8'h0};
        for (i = 0; i < 256; i++) begin
            if (i > 0) @(negedge clk_link_in);
            got = {got[254:0], sdo[p]};
            if (((sdo | bclk) & ~(4'h1 << p)) !== 4'h0) quiet = 1'b0;
        end
        run <= 1'b0;
        chk({31'h0, quiet}, 32'h1);
        for (i = 0; i < 8; i++) chk(got[255 - 32 * i -: 32], exp[255 - 32 * i -: 32]);
        repeat (10) @(posedge clk_sys_in);
    endtask
    task automatic t_clocks();
        int i;
        wr(spdaux_pkg::IDX_CTRL, 32'h0);
        gap <= 9'h010;
        run <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
        for (i = 0; i < 6; i++) begin
            @(posedge clk_sys_in);
            #0.5 chk({20'h0, fclk, bclk, sdo}, 32'h0);
        end
        run <= 1'b0;
        wr(spdaux_pkg::IDX_CTRL, 32'h03);
        repeat (10) @(posedge clk_sys_in);
        for (i = 0; i < 6; i++) begin
            @(posedge clk_sys_in);
            #0.5 chk({20'h0, fclk, bclk, sdo}, 32'h0);
        end
        wr(spdaux_pkg::IDX_CTRL, 32'h11);
        repeat (10) @(posedge clk_sys_in);
        for (i = 0; i < 40; i++) begin
            @(posedge clk_sys_in);
            #0.5 chk({30'h0, bclk[0], fclk[0]}, {30'h0, ~clk_link_in, cg3_fclk});
        end
        wr(spdaux_pkg::IDX_CTRL, 32'h01);
        repeat (10) @(posedge clk_sys_in);
        for (i = 0; i < 6; i++) begin
            @(posedge clk_sys_in);
            #0.5 chk({31'h0, bclk[0]}, {31'h0, clk_link_in});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        @(posedge clk_sys_in);
        t_reset();
        t_block();
        for (int p = 0; p < 4; p++) t_tdm(p);
        t_clocks();
        wrap_up();
    end
endmodule // spdaux_rx_aux_tb_top
